//--- design/arbiter_pkg.sv
package arbiter_pkg;

	// ascii codes used by the command framing and the time replies
	localparam logic [7:0] CHAR_CR    = 8'h0D;
	localparam logic [7:0] CHAR_SPACE = 8'h20;
	localparam logic [7:0] CHAR_ZERO  = 8'h30;
	localparam logic [7:0] CHAR_DOT   = 8'h2E;

	// command codes produced by the decoder
	typedef enum logic [3:0] {
		CMD_NONE      = 4'h0,
		CMD_REMOTE    = 4'h1,
		CMD_LOCAL     = 4'h2,
		CMD_VOLTS_A   = 4'h3,
		CMD_CURRENT_A = 4'h4,
		CMD_CLEAR_TRG = 4'h5,
		CMD_SRQ_ON    = 4'h6,
		CMD_SRQ_OFF   = 4'h7,
		CMD_TIME_QRY  = 4'h8,
		CMD_BAD       = 4'hF
	} cmd_t;

	// who holds remote control
	typedef enum logic [1:0] {
		OWN_LOCAL = 2'b00,
		OWN_BUS   = 2'b01,
		OWN_SER   = 2'b10
	} owner_t;

	// reply codes queued back to a port
	typedef enum logic [1:0] {
		RPL_NONE  = 2'b00,
		RPL_TIME  = 2'b01,
		RPL_ERROR = 2'b10
	} reply_t;

	localparam int          CMD_LEN       = 4;
	localparam logic [3:0]  DIGIT_MAX     = 4'h9;  // last decimal digit before carry
	// command spellings, first character in the highest byte in use
	localparam logic [31:0] TXT_REMOTE    = 32'h0052454D;
	localparam logic [31:0] TXT_LOCAL     = 32'h004C4F43;
	localparam logic [31:0] TXT_VOLTS_A   = 32'h00434156;
	localparam logic [31:0] TXT_CURRENT_A = 32'h00434149;
	localparam logic [31:0] TXT_CLEAR_TRG = 32'h00524553;
	localparam logic [31:0] TXT_TIME_QRY  = 32'h00505453;
	localparam logic [31:0] TXT_SRQ_ON    = 32'h53525131;
	localparam logic [31:0] TXT_SRQ_OFF   = 32'h53525130;
	localparam int          TIME_DIGITS   = 6;    // digits of the seconds reading
	localparam logic [7:0]  ERR_CHAR      = 8'h45; // 'E'
	localparam logic [7:0]  STATUS_BASE   = 8'h40; // rqs bit of the poll byte
	localparam logic [7:0]  STATUS_TRG    = 8'h01; // stop trigger seen
	// timer counts milliseconds: 200 MHz clock, 1 ms tick
	localparam int          CLK_MHZ       = 200;
	localparam int          TICK_US       = 1000;
	localparam int          TICK_CYCLES   = CLK_MHZ * TICK_US;

endpackage : arbiter_pkg

//--- design/port_if.sv
// one host port between the top and its command decoder
interface port_if;
	import arbiter_pkg::*;
	logic       rx_valid;
	logic [7:0] rx_data;
	logic       cmd_valid;
	cmd_t       cmd;
	logic       cmd_remote;   // command needs remote control
	modport decoder (input rx_valid, input rx_data, output cmd_valid, output cmd, output cmd_remote);
	modport core (output rx_valid, output rx_data, input cmd_valid, input cmd, input cmd_remote);
endinterface : port_if

//--- design/cmd_decoder.sv
// per-port input buffer; a carriage return closes and decodes the line
module cmd_decoder
	import arbiter_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// port side
	port_if.decoder   p
);

	logic [7:0] buf_q [CMD_LEN];
	logic [2:0] len_q;

	// remote commands must come from the controlling port
	function automatic logic is_remote(input cmd_t c);
		return c inside {CMD_REMOTE, CMD_LOCAL, CMD_VOLTS_A, CMD_CURRENT_A, CMD_CLEAR_TRG};
	endfunction : is_remote

	function automatic cmd_t decode(input logic [7:0] a, input logic [7:0] b,
	                                input logic [7:0] c, input logic [7:0] d,
	                                input logic [2:0] n);
		cmd_t        r;
		logic [31:0] w;
		r = CMD_BAD;
		// short spellings sit in the low three bytes with a zero top byte
		w = (n == 3'(CMD_LEN)) ? {a, b, c, d} : {8'h00, a, b, c};
		if (n == 3'(CMD_LEN - 1) || n == 3'(CMD_LEN)) begin
			case (w)
				TXT_REMOTE:    r = CMD_REMOTE;
				TXT_LOCAL:     r = CMD_LOCAL;
				TXT_VOLTS_A:   r = CMD_VOLTS_A;
				TXT_CURRENT_A: r = CMD_CURRENT_A;
				TXT_CLEAR_TRG: r = CMD_CLEAR_TRG;
				TXT_TIME_QRY:  r = CMD_TIME_QRY;
				TXT_SRQ_ON:    r = CMD_SRQ_ON;
				TXT_SRQ_OFF:   r = CMD_SRQ_OFF;
				default:       r = CMD_BAD;
			endcase
		end
		if (n == 3'h0) r = CMD_NONE;
		return r;
	endfunction : decode

	always_ff @(posedge clk) begin
		p.cmd_valid <= 1'b0;
		if (!rst_n) begin
			len_q        <= '0;
			p.cmd        <= CMD_NONE;
			p.cmd_remote <= 1'b0;
		end else if (p.rx_valid) begin
			if (p.rx_data == CHAR_CR) begin
				p.cmd_valid  <= 1'b1;
				p.cmd        <= decode(buf_q[0], buf_q[1], buf_q[2], buf_q[3], len_q);
				p.cmd_remote <= is_remote(decode(buf_q[0], buf_q[1], buf_q[2], buf_q[3], len_q));
				len_q        <= '0;
			end else if (p.rx_data != CHAR_SPACE) begin
				if (len_q < 3'(CMD_LEN)) buf_q[len_q[1:0]] <= p.rx_data;
				if (len_q != 3'd7) len_q <= len_q + 3'd1; // overlong lines decode as bad
			end
		end
	end

endmodule : cmd_decoder

//--- design/dual_port_remote_arbiter.sv
// What this block does
// - Both ports take and decode commands at the same time, each on its own.
// - When both ports contend in one cycle, the bus port wins control.
// - A bus claim takes control away from a serial holder.
// - Serial go-remote and go-local are ignored while the bus holds control.
// - Interrogation commands from the serial port still run while the bus controls.
// - Remote-control commands run only from the port holding control.
// - A serial remote-control command other than go-remote or go-local under bus control gets an error reply.
// - Each port has its own input and output buffer.
// - With service request on stop enabled, a stop trigger raises service request.
// - A serial poll returns a status byte on each talk request until poll disable ends it.
// - A time query, when talked, answers the seconds reading ending in carriage return.
// - Clear trigger status from the controlling port clears the trigger status.
module dual_port_remote_arbiter
	import arbiter_pkg::*;
#(
	parameter int TICK = TICK_CYCLES
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// bus port: listened bytes, talk strobe, poll and remote claim
	input  wire logic       bus_rx_valid,
	input  wire logic [7:0] bus_rx_data,
	input  wire logic       bus_talk_req,     // one byte requested while talker
	input  wire logic       bus_poll_active,  // between poll enable and disable
	input  wire logic       bus_remote_claim,
	output logic            bus_tx_valid,
	output logic [7:0]      bus_tx_data,
	output logic            service_request,
	// serial port
	input  wire logic       ser_rx_valid,
	input  wire logic [7:0] ser_rx_data,
	input  wire logic       ser_tx_ready,
	output logic            ser_tx_valid,
	output logic [7:0]      ser_tx_data,
	// instrument side
	input  wire logic       stop_trigger,
	output logic            remote_bus_q,
	output logic            remote_ser_q,
	output logic            volts_a_sel_q,
	output logic            current_a_sel_q,
	output logic            trigger_status_q
);

	////////////////////////////////////////////////////////////////////////////
	// decoders, one per port

	port_if bus_p ();
	port_if ser_p ();

	assign bus_p.rx_valid = bus_rx_valid;
	assign bus_p.rx_data  = bus_rx_data;
	assign ser_p.rx_valid = ser_rx_valid;
	assign ser_p.rx_data  = ser_rx_data;

	cmd_decoder u_bus_dec (
		.clk   (clk),
		.rst_n (rst_n),
		.p     (bus_p.decoder)
	);

	cmd_decoder u_ser_dec (
		.clk   (clk),
		.rst_n (rst_n),
		.p     (ser_p.decoder)
	);

	////////////////////////////////////////////////////////////////////////////
	// control ownership

	owner_t owner_q;
	owner_t owner_d;
	logic   bus_go_rem, bus_go_loc, ser_go_rem, ser_go_loc;
	logic   bus_ok, ser_ok;

	assign bus_go_rem = bus_remote_claim | (bus_p.cmd_valid && bus_p.cmd == CMD_REMOTE);
	assign bus_go_loc = bus_p.cmd_valid && bus_p.cmd == CMD_LOCAL;
	assign ser_go_rem = ser_p.cmd_valid && ser_p.cmd == CMD_REMOTE;
	assign ser_go_loc = ser_p.cmd_valid && ser_p.cmd == CMD_LOCAL;

	// remote commands only from the owner; nobody acts while local
	assign bus_ok = bus_p.cmd_valid && (!bus_p.cmd_remote || owner_q == OWN_BUS);
	assign ser_ok = ser_p.cmd_valid && (!ser_p.cmd_remote || owner_q == OWN_SER)
	                && !(bus_go_rem && ser_p.cmd_remote);

	// bus wins ties; bus claim preempts; serial ignored
	always_comb begin
		owner_d = owner_q;
		if (bus_go_rem) begin
			owner_d = OWN_BUS;
		end else if (bus_go_loc && owner_q == OWN_BUS) begin
			owner_d = OWN_LOCAL;
		end else if (owner_q != OWN_BUS && ser_go_rem) begin
			owner_d = OWN_SER;
		end else if (owner_q == OWN_SER && ser_go_loc) begin
			owner_d = OWN_LOCAL;
		end
	end

	// ownership flags are flops of their own so the pins never glitch
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			owner_q      <= OWN_LOCAL;
			remote_bus_q <= 1'b0;
			remote_ser_q <= 1'b0;
		end else begin
			owner_q      <= owner_d;
			remote_bus_q <= owner_d == OWN_BUS;
			remote_ser_q <= owner_d == OWN_SER;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// remote-control actions, bus first

	// selection commands from the owning port
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			volts_a_sel_q   <= 1'b0;
			current_a_sel_q <= 1'b0;
		end else begin
			if ((ser_ok && ser_p.cmd == CMD_VOLTS_A) || (bus_ok && bus_p.cmd == CMD_VOLTS_A)) begin
				volts_a_sel_q   <= 1'b1;
				current_a_sel_q <= 1'b0;
			end
			if ((ser_ok && ser_p.cmd == CMD_CURRENT_A) || (bus_ok && bus_p.cmd == CMD_CURRENT_A)) begin
				volts_a_sel_q   <= 1'b0;
				current_a_sel_q <= 1'b1;
			end
		end
	end

	// clear trigger status; a trigger in the same cycle wins
	logic srq_en_q, srq_q;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			trigger_status_q <= 1'b0;
		end else if (stop_trigger) begin
			trigger_status_q <= 1'b1;
		end else if ((bus_ok && bus_p.cmd == CMD_CLEAR_TRG) ||
		             (ser_ok && ser_p.cmd == CMD_CLEAR_TRG)) begin
			trigger_status_q <= 1'b0;
		end
	end

	// service request on stop trigger when enabled
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			srq_en_q <= 1'b0;
			srq_q    <= 1'b0;
		end else begin
			if (bus_ok && bus_p.cmd == CMD_SRQ_ON) srq_en_q <= 1'b1;
			else if (bus_ok && bus_p.cmd == CMD_SRQ_OFF) srq_en_q <= 1'b0;
			if (stop_trigger && srq_en_q) srq_q <= 1'b1;
			else if (bus_poll_active && bus_talk_req) srq_q <= 1'b0; // poll read acknowledges
		end
	end
	assign service_request = srq_q;

	////////////////////////////////////////////////////////////////////////////
	// seconds timer, millisecond resolution

	logic [31:0]          tick_q;
	logic [3:0]           digit_q [TIME_DIGITS]; // ms ones at index 0
	logic [TIME_DIGITS:0] carry;

	// ripple carry between decimal digits; the reading wraps after 999.999 s
	assign carry[0] = 1'b1;
	for (genvar g = 0; g < TIME_DIGITS; g++) begin : g_carry
		assign carry[g+1] = carry[g] && digit_q[g] == DIGIT_MAX;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tick_q <= '0;
			for (int i = 0; i < TIME_DIGITS; i++) digit_q[i] <= '0;
		end else if (tick_q == 32'(TICK - 1)) begin
			tick_q <= '0;
			for (int i = 0; i < TIME_DIGITS; i++) begin
				if (carry[i]) digit_q[i] <= (digit_q[i] == DIGIT_MAX) ? 4'h0 : digit_q[i] + 4'h1;
			end
		end else begin
			tick_q <= tick_q + 32'd1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// reply formatting: per-port output buffers

	// character k of "DDD.DDD<CR>" for a time snapshot
	function automatic logic [7:0] time_char(input logic [3:0] s [TIME_DIGITS], input int k);
		logic [7:0] r;
		r = CHAR_CR;
		if (k < 3) r = CHAR_ZERO + 8'(s[TIME_DIGITS - 1 - k]);
		else if (k == 3) r = CHAR_DOT;
		else if (k < 7) r = CHAR_ZERO + 8'(s[TIME_DIGITS - k]);
		return r;
	endfunction : time_char

	localparam int LAST = TIME_DIGITS + 1;

	// bus output: a pending time reply is paced by talk requests
	logic [3:0] bus_snap_q [TIME_DIGITS];
	logic       bus_pend_q;
	logic [3:0] bus_idx_q;
	// poll byte or timer reading on each talk request
	always_ff @(posedge clk) begin
		bus_tx_valid <= 1'b0;
		if (!rst_n) begin
			bus_pend_q  <= 1'b0;
			bus_idx_q   <= '0;
			bus_tx_data <= '0;
		end else begin
			if (bus_ok && bus_p.cmd == CMD_TIME_QRY) begin
				bus_pend_q <= 1'b1;
				bus_idx_q  <= '0;
				bus_snap_q <= digit_q;
			end else if (bus_talk_req && bus_poll_active) begin
				bus_tx_valid <= 1'b1;
				bus_tx_data  <= (srq_q ? STATUS_BASE : 8'h00) | (trigger_status_q ? STATUS_TRG : 8'h00);
			end else if (bus_talk_req && bus_pend_q) begin
				bus_tx_valid <= 1'b1;
				bus_tx_data  <= time_char(bus_snap_q, int'(bus_idx_q));
				bus_idx_q    <= bus_idx_q + 4'd1;
				if (bus_idx_q == 4'(LAST)) bus_pend_q <= 1'b0;
			end
		end
	end

	// serial output: time reply or error, streamed under ready
	logic [3:0] ser_snap_q [TIME_DIGITS];
	reply_t     ser_rpl_q;
	logic [3:0] ser_idx_q;
	reply_t     ser_want_q;
	logic       ser_take;

	// a reply asked for while the last one drains waits here, one deep,
	// so one command pulse is kept behind a stalled host; a second one overwrites it
	assign ser_take = ser_want_q != RPL_NONE && ser_rpl_q == RPL_NONE
	                  && !(ser_tx_valid && !ser_tx_ready);

	// queries allowed; refused remote command other than go-remote or go-local answers error
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ser_want_q <= RPL_NONE;
		end else if (ser_ok && ser_p.cmd == CMD_TIME_QRY) begin
			ser_want_q <= RPL_TIME;
		end else if (ser_p.cmd_valid && ser_p.cmd_remote && !ser_ok
		             && !(ser_p.cmd inside {CMD_REMOTE, CMD_LOCAL})) begin
			ser_want_q <= RPL_ERROR;
		end else if (ser_take) begin
			ser_want_q <= RPL_NONE;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ser_rpl_q    <= RPL_NONE;
			ser_idx_q    <= '0;
			ser_tx_valid <= 1'b0;
			ser_tx_data  <= '0;
		end else if (ser_tx_valid && !ser_tx_ready) begin
			ser_tx_valid <= 1'b1; // hold byte until taken
		end else if (ser_rpl_q == RPL_TIME) begin
			ser_tx_valid <= 1'b1;
			ser_tx_data  <= time_char(ser_snap_q, int'(ser_idx_q));
			ser_idx_q    <= ser_idx_q + 4'd1;
			if (ser_idx_q == 4'(LAST)) ser_rpl_q <= RPL_NONE;
		end else if (ser_rpl_q == RPL_ERROR) begin
			ser_tx_valid <= 1'b1;
			ser_tx_data  <= (ser_idx_q == 4'd0) ? ERR_CHAR : CHAR_CR;
			ser_idx_q    <= ser_idx_q + 4'd1;
			if (ser_idx_q == 4'd1) ser_rpl_q <= RPL_NONE;
		end else begin
			ser_tx_valid <= 1'b0;
			ser_idx_q    <= '0;
			// start the waiting reply; the timer is snapped as it begins
			if (ser_take) begin
				ser_rpl_q  <= ser_want_q;
				ser_snap_q <= digit_q;
			end
		end
	end

endmodule : dual_port_remote_arbiter

//--- testbench/arbiter_monitor.sv
module arbiter_monitor
	import arbiter_pkg::*;
(
	// clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// bus port
	input wire logic       bus_talk_req,
	input wire logic       bus_poll_active,
	input wire logic       bus_remote_claim,
	input wire logic       bus_tx_valid,
	input wire logic [7:0] bus_tx_data,
	input wire logic       service_request,
	// serial port and instrument
	input wire logic       ser_tx_ready,
	input wire logic       ser_tx_valid,
	input wire logic [7:0] ser_tx_data,
	input wire logic       stop_trigger,
	input wire logic       remote_bus_q,
	input wire logic       remote_ser_q,
	input wire logic       trigger_status_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////
	// one talk strobe, one byte on the next edge
	sequence s_talk;
		bus_talk_req ##1 bus_tx_valid;
	endsequence
	sequence s_poll;
		bus_poll_active && bus_talk_req ##1 bus_tx_valid;
	endsequence
	property p_one_owner; !(remote_bus_q && remote_ser_q); endproperty
	a_one_owner: assert property (p_one_owner) else $error("two owners");
	property p_claim; bus_remote_claim |-> ##[1:3] remote_bus_q; endproperty
	a_claim: assert property (p_claim) else $error("claim not taken");
	property p_no_seize; $rose(remote_ser_q) |-> !$past(remote_bus_q); endproperty
	a_no_seize: assert property (p_no_seize) else $error("serial seized");
	property p_talk; bus_talk_req |-> s_talk; endproperty
	a_talk: assert property (p_talk) else $error("talk unanswered");
	property p_answer; bus_tx_valid |-> $past(bus_talk_req); endproperty
	a_answer: assert property (p_answer) else $error("byte not asked");
	property p_ser_hold;
		ser_tx_valid && !ser_tx_ready |=> ser_tx_valid && $stable(ser_tx_data);
	endproperty
	a_ser_hold: assert property (p_ser_hold) else $error("reply dropped");
	property p_trg; stop_trigger |=> trigger_status_q; endproperty
	a_trg: assert property (p_trg) else $error("trigger lost");
	property p_srq; $rose(service_request) |-> trigger_status_q; endproperty
	a_srq: assert property (p_srq) else $error("request without stop");
	// poll byte mirrors the request and trigger flags
	property p_poll;
		s_poll |-> bus_tx_data == {1'b0, $past(service_request), 5'h00,
			$past(trigger_status_q)};
	endproperty
	a_poll: assert property (p_poll) else $error("bad status byte");
	property p_srq_clr;
		$fell(service_request) |-> $past(bus_talk_req) && $past(bus_poll_active);
	endproperty
	a_srq_clr: assert property (p_srq_clr) else $error("request cleared early");
endmodule : arbiter_monitor

bind dual_port_remote_arbiter arbiter_monitor u_arbiter_monitor (.clk, .rst_n,
	.bus_talk_req, .bus_poll_active, .bus_remote_claim, .bus_tx_valid, .bus_tx_data,
	.service_request, .ser_tx_ready, .ser_tx_valid, .ser_tx_data, .stop_trigger,
	.remote_bus_q, .remote_ser_q, .trigger_status_q);

//--- testbench/host_pair_model.sv
module host_pair_model (
	// clock
	input  wire logic  clk,
	// bus controller and serial host
	output logic       bus_rx_valid,
	output logic [7:0] bus_rx_data,
	output logic       bus_talk_req,
	output logic       ser_rx_valid,
	output logic [7:0] ser_rx_data,
	output logic       ser_tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	integer     seed = 11520;
	logic       v[2];
	logic [7:0] d[2];
	// index 0 is the bus controller, 1 the serial host
	assign bus_rx_valid = v[0];
	assign bus_rx_data  = d[0];
	assign ser_rx_valid = v[1];
	assign ser_rx_data  = d[1];
	initial begin
		v = '{1'b0, 1'b0};
		d = '{8'h00, 8'h00};
		bus_talk_req = 1'b0;
		ser_tx_ready = 1'b1;
	end
	// host stalls at random so held replies are exercised
	always @(posedge clk) ser_tx_ready <= ($random(seed) % 4) != 0;
	////////////////////////////////////////////////////////////////
	// line closed by carriage return
	task automatic send(input int p, input logic [31:0] w, input int n);
		logic [7:0] c;
		for (int i = 0; i <= n; i++) begin
			c = 8'h0D;
			if (i < n) c = w[8*(n-1-i) +: 8];
			@(posedge clk);
			v[p] <= 1'b1;
			d[p] <= c;
		end
		@(posedge clk);
		v[p] <= 1'b0;
		d[p] <= ~c; // idle data never repeats the last byte
	endtask : send
	task automatic talk(input int n);
		repeat (n) begin
			@(posedge clk);
			bus_talk_req <= 1'b1;
		end
		@(posedge clk);
		bus_talk_req <= 1'b0;
	endtask : talk
endmodule : host_pair_model

//--- testbench/dual_port_remote_arbiter_tb.sv
module dual_port_remote_arbiter_tb
	import arbiter_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk, rst_n, bus_rx_valid, bus_talk_req, bus_poll_active, bus_remote_claim;
	logic       bus_tx_valid, service_request, ser_rx_valid, ser_tx_ready, ser_tx_valid;
	logic       stop_trigger, remote_bus_q, remote_ser_q, volts_a_sel_q, current_a_sel_q;
	logic       trigger_status_q;
	logic [7:0] bus_rx_data, bus_tx_data, ser_rx_data, ser_tx_data;
	logic [7:0] qb[$], qs[$];
	int         err_count = 0;
	int         checks_done = 0;
	logic [31:0] rc[3] = '{TXT_VOLTS_A, TXT_CURRENT_A, TXT_CLEAR_TRG};
	always #2.5 clk = ~clk;
	dual_port_remote_arbiter #(.TICK(10)) u_dual_port_remote_arbiter (.clk, .rst_n,
		.bus_rx_valid, .bus_rx_data, .bus_talk_req, .bus_poll_active, .bus_remote_claim,
		.bus_tx_valid, .bus_tx_data, .service_request, .ser_rx_valid, .ser_rx_data,
		.ser_tx_ready, .ser_tx_valid, .ser_tx_data, .stop_trigger, .remote_bus_q,
		.remote_ser_q, .volts_a_sel_q, .current_a_sel_q, .trigger_status_q);
	host_pair_model u_host_pair_model (.clk, .bus_rx_valid, .bus_rx_data, .bus_talk_req,
		.ser_rx_valid, .ser_rx_data, .ser_tx_ready);
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic chkb(input logic b, input logic e);
		chk({7'h00, b}, {7'h00, e});
	endtask : chkb
	// a '?' note stands for any decimal digit of the timer
	task automatic chk_q(input logic [7:0] v, ref logic [7:0] q[$]);
		logic [7:0] e;
		e = q.size() ? q.pop_front() : 8'hXX;
		if (e == 8'h3F) chk({7'h00, v inside {[8'h30:8'h39]}}, 8'h01);
		else chk(v, e);
	endtask : chk_q
	task automatic push(ref logic [7:0] q[$], input string s);
		foreach (s[i]) q.push_back(s[i]);
		q.push_back(8'h0D);
	endtask : push
	task automatic settle();
		repeat (4) @(posedge clk);
	endtask : settle
	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_sim
	// replies are matched in order against the driver's notes
	always @(posedge clk) begin
		if (bus_tx_valid) chk_q(bus_tx_data, qb);
		if (ser_tx_valid && ser_tx_ready) chk_q(ser_tx_data, qs);
	end
	// a hang ends the run as a failure
	initial begin
		#50000;
		err_count++;
		end_sim();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		bus_poll_active = 1'b0;
		bus_remote_claim = 1'b0;
		stop_trigger = 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		// serial host takes control and selects volts
		u_host_pair_model.send(1, TXT_REMOTE, 3);
		u_host_pair_model.send(1, TXT_VOLTS_A, 3);
		settle();
		chkb(remote_ser_q, 1'b1);
		chkb(volts_a_sel_q, 1'b1);
		// bus claim takes control away
		@(posedge clk);
		bus_remote_claim <= 1'b1;
		@(posedge clk);
		bus_remote_claim <= 1'b0;
		settle();
		chkb(remote_bus_q, 1'b1);
		// serial go-local and go-remote are ignored now
		u_host_pair_model.send(1, TXT_LOCAL, 3);
		u_host_pair_model.send(1, TXT_REMOTE, 3);
		settle();
		chkb(remote_ser_q, 1'b0);
		chkb(remote_bus_q, 1'b1);
		// request on stop, then a stop trigger
		u_host_pair_model.send(0, TXT_SRQ_ON, 4);
		settle();
		stop_trigger <= 1'b1;
		@(posedge clk);
		stop_trigger <= 1'b0;
		for (int i = 0; i < 20 && service_request !== 1'b1; i++) @(posedge clk);
		chkb(service_request, 1'b1);
		// serial remote commands are refused with an error line
		foreach (rc[i]) begin
			push(qs, "E");
			u_host_pair_model.send(1, rc[i], 3);
		end
		settle();
		chkb(current_a_sel_q, 1'b0);
		chkb(trigger_status_q, 1'b1);
		// both ports query time at once, buffers kept apart
		push(qs, "???.???");
		push(qb, "???.???");
		fork
			u_host_pair_model.send(0, TXT_TIME_QRY, 3);
			u_host_pair_model.send(1, TXT_TIME_QRY, 3);
		join
		settle();
		u_host_pair_model.talk(8);
		// serial poll reads one status byte, then ends
		qb.push_back(8'h41);
		@(posedge clk);
		bus_poll_active <= 1'b1;
		u_host_pair_model.talk(1);
		bus_poll_active <= 1'b0;
		settle();
		chkb(service_request, 1'b0);
		// with the request disabled a stop trigger raises nothing
		u_host_pair_model.send(0, TXT_SRQ_OFF, 4);
		settle();
		stop_trigger <= 1'b1;
		@(posedge clk);
		stop_trigger <= 1'b0;
		settle();
		chkb(service_request, 1'b0);
		chkb(trigger_status_q, 1'b1);
		// controlling bus selects current and clears trigger
		u_host_pair_model.send(0, TXT_CURRENT_A, 3);
		u_host_pair_model.send(0, TXT_CLEAR_TRG, 3);
		settle();
		chkb(current_a_sel_q, 1'b1);
		chkb(trigger_status_q, 1'b0);
		for (int i = 0; i < 400 && (qb.size() || qs.size()); i++) @(posedge clk);
		chk(8'(qb.size() + qs.size()), 8'h00);
		end_sim();
	end
endmodule : dual_port_remote_arbiter_tb
